// file: hw/lswp_pkg.sv
// Package of constants and types for the load step wakeup pulser.
package lswp_pkg;
	localparam int unsigned CLK_FREQ_HZ          = 40_000_000;
	localparam int unsigned REPEAT_PERIOD_NS     = 4000;
	localparam int unsigned REPEAT_PERIOD_CYC    = REPEAT_PERIOD_NS / (1_000_000_000 / CLK_FREQ_HZ);
	localparam int unsigned PULSE_WIDTH_NS_DFLT  = 1000;
	localparam int unsigned ENABLE_DELAY_NS_DFLT = 100_000;
	localparam int unsigned CLK_PERIOD_NS        = 1_000_000_000 / CLK_FREQ_HZ;
	localparam int unsigned SYNC_STAGES          = 2;
	localparam int unsigned CNT_W                = 24;
	localparam int unsigned SLOT_W               = 12;

	typedef enum logic [1:0] {
		LSWP_IDLE,
		LSWP_WAIT,
		LSWP_PULSE,
		LSWP_GAP
	} lswp_state_t;

	typedef struct packed {
		logic supply_low;
		logic gate_drive;
		logic drain_sense;
	} lswp_pins_t;
endpackage

// file: hw/lswp_sync.sv
// Two flip-flop synchroniser for a group of pin levels.
`timescale 1ns/10ps
module lswp_sync
	import lswp_pkg::*;
#(
	parameter int unsigned WIDTH = 3
) (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// file: hw/lswp_top.sv
// Load step wakeup pulser: times gate idle and drives repeated sink pulses.
`timescale 1ns/10ps
module lswp_top
	import lswp_pkg::*;
#(
	parameter int unsigned PULSE_WIDTH_NS  = PULSE_WIDTH_NS_DFLT,
	parameter int unsigned ENABLE_DELAY_NS = ENABLE_DELAY_NS_DFLT
) (
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic supply_low_in,
	input  wire logic gate_drive_in,
	input  wire logic drain_sense_in,
	output logic      sink_enable_q,
	output logic      wakeup_armed_q
);
	localparam int unsigned PULSE_CYC = (PULSE_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DELAY_CYC = ENABLE_DELAY_NS / CLK_PERIOD_NS;
	localparam logic [SLOT_W-1:0] PULSE_LAST = SLOT_W'(PULSE_CYC - 1);
	localparam logic [SLOT_W-1:0] SLOT_LAST  = SLOT_W'(REPEAT_PERIOD_CYC - 1);
	localparam logic [CNT_W-1:0]  DELAY_LIM  = CNT_W'(DELAY_CYC);
	localparam logic [CNT_W-1:0]  CNT_MAX    = {CNT_W{1'b1}};

	initial begin
		if (PULSE_CYC < 1 || PULSE_CYC >= REPEAT_PERIOD_CYC)
			$error("Pulse width must be at least one cycle and shorter than the repeat period.");
		if (DELAY_CYC < 1 || DELAY_CYC >= (2 ** CNT_W) - 1)
			$error("Enable delay does not fit the elapsed counter.");
	end

	lswp_pins_t  pins_raw;
	lswp_pins_t  pins_s;
	logic        gate_prev_q;
	logic        drain_prev_q;
	logic        gate_rise;
	logic        drain_rise;
	logic [CNT_W-1:0]  elapsed_q;
	logic [SLOT_W-1:0] slot_q;
	lswp_state_t state_q;
	lswp_state_t state_d;
	logic        armed;

	assign pins_raw.supply_low  = supply_low_in;
	assign pins_raw.gate_drive  = gate_drive_in;
	assign pins_raw.drain_sense = drain_sense_in;

	// Pins are synchronised before any logic looks at them.
	lswp_sync #(
		.WIDTH ($bits(lswp_pins_t))
	) u_sync (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.async_in (pins_raw),
		.sync_out (pins_s)
	);

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			gate_prev_q  <= 1'b0;
			drain_prev_q <= 1'b0;
		end else begin
			gate_prev_q  <= pins_s.gate_drive;
			drain_prev_q <= pins_s.drain_sense;
		end
	end

	assign gate_rise  = pins_s.gate_drive & ~gate_prev_q;
	assign drain_rise = pins_s.drain_sense & ~drain_prev_q;

	// Elapsed time since the last gate edge, saturating.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			elapsed_q <= '0;
		end else if (gate_rise) begin
			elapsed_q <= '0;
		end else if (elapsed_q != CNT_MAX) begin
			elapsed_q <= elapsed_q + CNT_W'(1);
		end
	end

	assign armed = (elapsed_q > DELAY_LIM);

	always_comb begin
		state_d = state_q;
		case (state_q)
			LSWP_IDLE: begin
				if (armed && pins_s.supply_low && !gate_rise && !drain_rise) begin
					state_d = LSWP_PULSE;
				end
			end
			LSWP_WAIT: begin
				if (gate_rise) begin
					state_d = LSWP_IDLE;
				end
			end
			LSWP_PULSE: begin
				if (drain_rise || gate_rise) begin
					state_d = LSWP_WAIT;
				end else if (slot_q == PULSE_LAST) begin
					state_d = LSWP_GAP;
				end
			end
			LSWP_GAP: begin
				if (drain_rise || gate_rise) begin
					state_d = LSWP_WAIT;
				end else if (slot_q == SLOT_LAST) begin
					state_d = pins_s.supply_low ? LSWP_PULSE : LSWP_IDLE;
				end
			end
			default: begin
				state_d = LSWP_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_q <= LSWP_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Position inside the current repeat slot.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			slot_q <= '0;
		end else if (state_d == LSWP_PULSE && state_q != LSWP_PULSE) begin
			slot_q <= '0;
		end else if (state_q == LSWP_PULSE || state_q == LSWP_GAP) begin
			slot_q <= slot_q + SLOT_W'(1);
		end else begin
			slot_q <= '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sink_enable_q  <= 1'b0;
			wakeup_armed_q <= 1'b0;
		end else begin
			sink_enable_q  <= (state_q == LSWP_PULSE);
			wakeup_armed_q <= armed;
		end
	end

	sequence s_pulse_start;
		$rose(sink_enable_q);
	endsequence

	sequence s_slot_end;
		state_q == LSWP_GAP && slot_q == SLOT_LAST;
	endsequence

	sequence s_edge_seen;
		drain_rise || gate_rise;
	endsequence

	chk_idle_when_high: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == LSWP_IDLE && !pins_s.supply_low)
		|=> state_q != LSWP_PULSE)
		else $error("Pulse started while the supply was not low.");
	chk_idle_no_sink: assert property (@(posedge clk_sys) disable iff (rst)
		state_q == LSWP_IDLE
		|=> !sink_enable_q)
		else $error("Sink enabled while the sequencer was idle.");
	chk_no_arm_early: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == LSWP_IDLE && !armed)
		|=> state_q != LSWP_PULSE)
		else $error("Pulse started before the wakeup logic armed.");
	chk_armed_output: assert property (@(posedge clk_sys) disable iff (rst)
		1'b1
		|-> wakeup_armed_q == $past(armed))
		else $error("Armed output does not follow the armed condition.");
	chk_gate_clears_arm: assert property (@(posedge clk_sys) disable iff (rst)
		gate_rise
		|=> ##1 !wakeup_armed_q)
		else $error("Gate edge did not clear the armed output.");
	chk_slot_bound: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == LSWP_PULSE || state_q == LSWP_GAP)
		|-> slot_q <= SLOT_LAST)
		else $error("Slot position ran past the repeat period.");
	chk_gap_leaves: assert property (@(posedge clk_sys) disable iff (rst)
		s_slot_end
		|=> state_q != LSWP_GAP)
		else $error("Gap outlasted the repeat slot.");
	chk_pulse_slot_max: assert property (@(posedge clk_sys) disable iff (rst)
		state_q == LSWP_PULSE
		|-> slot_q <= PULSE_LAST)
		else $error("Pulse state outlasted the pulse width.");
	chk_edge_ends: assert property (@(posedge clk_sys) disable iff (rst)
		s_edge_seen ##0 (state_q == LSWP_PULSE || state_q == LSWP_GAP)
		|=> state_q == LSWP_WAIT)
		else $error("Switching edge did not end the pulse train.");
	chk_wait_no_sink: assert property (@(posedge clk_sys) disable iff (rst)
		state_q == LSWP_WAIT
		|=> !sink_enable_q)
		else $error("Sink enabled after the train was stopped.");
	chk_wait_holds: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == LSWP_WAIT && !gate_rise)
		|=> state_q == LSWP_WAIT)
		else $error("Stopped train resumed without a gate edge.");

	chk_pulse_needs_low: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(state_q == LSWP_PULSE) |-> $past(pins_s.supply_low))
		else $error("Sink pulse started without supply low.");
	chk_gate_restarts: assert property (@(posedge clk_sys) disable iff (rst)
		gate_rise |=> elapsed_q == '0)
		else $error("Gate edge did not restart the elapsed count.");
	chk_arm_after_delay: assert property (@(posedge clk_sys) disable iff (rst)
		$rose(state_q == LSWP_PULSE) |-> $past(elapsed_q) > DELAY_LIM)
		else $error("Pulse issued before the enable delay passed.");
	chk_repeat_period: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == LSWP_GAP && slot_q == SLOT_LAST && pins_s.supply_low && !drain_rise && !gate_rise)
		|=> state_q == LSWP_PULSE && slot_q == '0)
		else $error("Pulse did not repeat at the slot boundary.");
	chk_drain_stops: assert property (@(posedge clk_sys) disable iff (rst)
		(drain_rise && (state_q == LSWP_PULSE || state_q == LSWP_GAP)) |=> ##1 !sink_enable_q)
		else $error("Sink kept running after a drain edge.");
	chk_pulse_width: assert property (@(posedge clk_sys) disable iff (rst)
		(state_q == LSWP_PULSE && slot_q == PULSE_LAST && !drain_rise && !gate_rise)
		|=> state_q == LSWP_GAP ##1 !sink_enable_q)
		else $error("Sink pulse width is wrong.");
	chk_pulse_follows: assert property (@(posedge clk_sys) disable iff (rst)
		s_pulse_start |-> $past(state_q == LSWP_PULSE))
		else $error("Sink enable not led by the pulse state.");
	chk_sync_delay: assert property (@(posedge clk_sys) disable iff (rst)
		pins_s.gate_drive == $past(gate_drive_in, 2) || $past(rst, 2))
		else $error("Gate input not passed through two stages.");
endmodule

// file: test/lswp_primary_model.sv
// Primary controller model that resumes switching after a seen sink pulse.
`timescale 1ns/10ps
module lswp_primary_model (
	input  wire logic clk_sys,
	input  wire logic kick,
	input  wire logic respond,
	input  wire logic sink_enable_q,
	output logic      drain_sense_in = 1'b0,
	output logic      gate_drive_in = 1'b0
);
	int unsigned cnt = 0;
	// A seen sink pulse or a bench kick starts one switching cycle.
	always @(posedge clk_sys) begin
		if (cnt == 45)
			cnt <= 0;
		else if (cnt != 0)
			cnt <= cnt + 1;
		else if (kick || (respond && sink_enable_q))
			cnt <= 1;
		drain_sense_in <= (cnt >= 10 && cnt < 20);
		gate_drive_in <= (cnt >= 30 && cnt < 40);
	end
endmodule

// file: test/testbench.sv
// Testbench for the load step wakeup pulser.
`timescale 1ns/10ps
module testbench;
	import lswp_pkg::*;
	logic clk_sys, rst, supply_low_in, kick, respond;
	logic gate_drive_in, drain_sense_in, sink_enable_q, wakeup_armed_q;
	int   n_mismatch, n_checks, cyc, n, m;
	lswp_top #(.PULSE_WIDTH_NS(1000), .ENABLE_DELAY_NS(1000)) u_lswp_top (.clk_sys(clk_sys), .rst(rst),
		.supply_low_in(supply_low_in), .gate_drive_in(gate_drive_in), .drain_sense_in(drain_sense_in),
		.sink_enable_q(sink_enable_q), .wakeup_armed_q(wakeup_armed_q));
	lswp_primary_model u_lswp_primary_model (.clk_sys(clk_sys), .kick(kick), .respond(respond),
		.sink_enable_q(sink_enable_q), .drain_sense_in(drain_sense_in), .gate_drive_in(gate_drive_in));
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic chk(input logic seen, input logic exp, input string nm);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %b seen %b", nm, exp, seen);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask
	task automatic wait_sink(input logic lvl, input int lim, output int c);
		c = 0;
		while (sink_enable_q !== lvl && c < lim) begin
			tick(1);
			c++;
		end
	endtask
	task automatic do_kick;
		@(posedge clk_sys) kick <= 1'b1;
		@(posedge clk_sys) kick <= 1'b0;
	endtask
	task automatic t_arm;
		do_kick();
		tick(50);
		chk(wakeup_armed_q, 1'b0, "armed early");
		tick(60);
		chk(wakeup_armed_q, 1'b1, "armed late");
		chk(sink_enable_q, 1'b0, "sink supply ok");
		$display("t_arm done");
	endtask
	task automatic t_train;
		@(posedge clk_sys) supply_low_in <= 1'b1;
		wait_sink(1'b1, 20, n);
		chk(sink_enable_q, 1'b1, "sink start");
		wait_sink(1'b0, 300, n);
		chk(n == 40, 1'b1, "pulse width");
		wait_sink(1'b1, 300, m);
		chk(n + m == REPEAT_PERIOD_CYC, 1'b1, "repeat period");
		@(posedge clk_sys) supply_low_in <= 1'b0;
		wait_sink(1'b0, 60, n);
		tick(200);
		chk(sink_enable_q, 1'b0, "no pulse when high");
		$display("t_train done");
	endtask
	task automatic t_stop;
		do_kick();
		tick(120);
		@(posedge clk_sys) begin
			respond <= 1'b1;
			supply_low_in <= 1'b1;
		end
		wait_sink(1'b1, 20, n);
		wait_sink(1'b0, 60, n);
		chk(n <= 16, 1'b1, "drain stop");
		tick(40);
		chk(wakeup_armed_q, 1'b0, "gate restart");
		chk(sink_enable_q, 1'b0, "sink stopped");
		@(posedge clk_sys) supply_low_in <= 1'b0;
		$display("t_stop done");
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			test_done();
		end
	end
	initial begin
		{rst, supply_low_in, kick, respond} = 4'h8;
		{n_mismatch, n_checks, cyc} = '0;
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		tick(1);
		chk(sink_enable_q, 1'b0, "sink reset");
		chk(wakeup_armed_q, 1'b0, "armed reset");
		t_arm();
		t_train();
		t_stop();
		test_done();
	end
endmodule
